// ==== include/lsd_regs.svh ====
// register map, field positions, reset values and timing figures of the light sensor core
// assumes: included by the core and the bench by bare name
`ifndef LSD_REGS_SVH
`define LSD_REGS_SVH

// ------------------------------------------------------------
// command codes
// ------------------------------------------------------------
`define LSD_CMD_CFG 8'h00
`define LSD_CMD_HTH 8'h01
`define LSD_CMD_LTH 8'h02
`define LSD_CMD_PWR 8'h03
`define LSD_CMD_AMB 8'h04
`define LSD_CMD_WHT 8'h05
`define LSD_CMD_STS 8'h06

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define LSD_CFG_RST 16'h0001
`define LSD_CFG_SHUTDOWN 0
`define LSD_CFG_IRQ_EN 1
`define LSD_CFG_IT_HI 9
`define LSD_CFG_IT_LO 6
`define LSD_CFG_GAIN_HI 12
`define LSD_CFG_GAIN_LO 11
`define LSD_PWR_EN_BIT 0
`define LSD_STS_BELOW 15
`define LSD_STS_ABOVE 14

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define LSD_CLK_NS 20
`define LSD_MS_NS 1000000
`define LSD_MS_CYCLES (`LSD_MS_NS / `LSD_CLK_NS)
`define LSD_PWR_BASE_MS 13'h1f4
`define LSD_IT25_MS 13'h019
`define LSD_IT50_MS 13'h032
`define LSD_IT100_MS 13'h064
`define LSD_IT200_MS 13'h0c8
`define LSD_IT400_MS 13'h190
`define LSD_IT800_MS 13'h320

`endif

// ==== include/lsd_pkg.sv ====
// types of the light sensor core: serial engine states and the state record
// assumes: nothing beyond the register header
package lsd_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_AACK = 4'h3,
        ST_CMD = 4'h2,
        ST_CACK = 4'h6,
        ST_WR = 4'h7,
        ST_WACK = 4'h5,
        ST_RD = 4'h4,
        ST_RACK = 4'hc
    } lsd_state_t;

    typedef struct packed {
        logic scl1;
        logic scl2;
        logic scl3;
        logic sda1;
        logic sda2;
        logic sda3;
        logic scl_f;
        logic sda_f;
        lsd_state_t st;
        logic [3:0] cnt;
        logic [7:0] sr;
        logic [7:0] tx;
        logic [15:0] word;
        logic [7:0] wlo;
        logic [7:0] cmd;
        logic rw;
        logic hi;
        logic nack;
        logic oe;
        logic [15:0] cfg;
        logic [15:0] hthr;
        logic [15:0] lthr;
        logic [2:0] pwr;
        logic [15:0] amb;
        logic [15:0] wht;
        logic above;
        logic below;
        logic [15:0] ms_cnt;
        logic [12:0] ref_ms;
        logic tick;
    } lsd_regs_t;

endpackage : lsd_pkg

// ==== core/lsd_core.sv ====
// register side of the ambient light sensor: two-wire slave, command registers,
// window flags and refresh timer
// assumes: SCL/SDA arrive asynchronously; converter results arrive on CLK with a valid pulse
//
// Operation
// - power save bits 2:1 of code 03h select mode 1 to 4
// - bit 0 of code 03h enables power saving with selected mode
// - bits 15:3 of code 03h reserved, not stored, no function
// - read of code 04h returns 16-bit ambient result
// - ambient word: high byte in bits 15:8, low byte in 7:0
// - read of code 05h returns white result, same byte placement
// - status bit 15 set when data crosses low window threshold
// - status bit 14 set on high threshold crossing; bits 13:0 reserved
// - both window flags are read-only to the host
// - code 01h holds 16-bit high threshold used for crossing detection
// - code 02h holds 16-bit low threshold used for crossing detection
// - crossing events only while configuration bit 1 is set
// - refresh interval from mode and integration time, e.g. 600/1100/4100 ms
`include "lsd_regs.svh"
`timescale 1ns/100ps

module lsd_core #(
    parameter logic [6:0] DEV_ADDR = 7'h2a,  // arbitrary value
    parameter logic [15:0] MS_CYCLES = 16'(`LSD_MS_CYCLES)
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // two-wire bus
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // converter side
    input wire logic SAMPLE_VALID,
    input wire logic [15:0] AMBIENT_DATA,
    input wire logic [15:0] WHITE_DATA,
    output logic REFRESH_TICK,
    output logic SHUTDOWN,
    output logic [1:0] GAIN_SELECT,
    output logic [3:0] INTEGRATION_PERIOD,
    output logic POWER_SAVE_ENABLE,
    output logic [1:0] POWER_SAVE_MODE
);
    import lsd_pkg::*;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    lsd_regs_t q;
    lsd_regs_t n;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic wr_fire;
    logic rd_done;
    logic [15:0] wr_word;
    logic [15:0] rd_mux;
    logic [12:0] it_ms;
    logic [12:0] period;

    always_comb begin
        case (q.cmd)
            `LSD_CMD_CFG: rd_mux = q.cfg;
            `LSD_CMD_HTH: rd_mux = q.hthr;
            `LSD_CMD_LTH: rd_mux = q.lthr;
            `LSD_CMD_PWR: rd_mux = {13'h0000, q.pwr};
            `LSD_CMD_AMB: rd_mux = q.amb;
            `LSD_CMD_WHT: rd_mux = q.wht;
            `LSD_CMD_STS: rd_mux = {q.below, q.above, 14'h0000};
            default: rd_mux = 16'h0000;
        endcase
        case (q.cfg[`LSD_CFG_IT_HI:`LSD_CFG_IT_LO])
            4'hc: it_ms = `LSD_IT25_MS;
            4'h8: it_ms = `LSD_IT50_MS;
            4'h1: it_ms = `LSD_IT200_MS;
            4'h2: it_ms = `LSD_IT400_MS;
            4'h3: it_ms = `LSD_IT800_MS;
            default: it_ms = `LSD_IT100_MS;
        endcase
        // power saving adds 500 ms doubled per mode step
        if (q.pwr[`LSD_PWR_EN_BIT]) begin
            period = (`LSD_PWR_BASE_MS << q.pwr[2:1]) + it_ms;
        end else begin
            period = it_ms;
        end
    end

    always_comb begin
        n = q;
        wr_fire = 1'b0;
        rd_done = 1'b0;
        wr_word = {q.sr, q.wlo};
        n.tick = 1'b0;
        // ------------------------------------------------------------
        // pin sampling: a level counts once stages two and three agree
        // ------------------------------------------------------------
        n.scl1 = SCL_IN;
        n.scl2 = q.scl1;
        n.scl3 = q.scl2;
        n.sda1 = SDA_IN;
        n.sda2 = q.sda1;
        n.sda3 = q.sda2;
        n.scl_f = (q.scl2 == q.scl3) ? q.scl3 : q.scl_f;
        n.sda_f = (q.sda2 == q.sda3) ? q.sda3 : q.sda_f;
        scl_rise = n.scl_f & ~q.scl_f;
        scl_fall = ~n.scl_f & q.scl_f;
        start_c = q.scl_f & n.scl_f & q.sda_f & ~n.sda_f;
        stop_c = q.scl_f & n.scl_f & ~q.sda_f & n.sda_f;
        // ------------------------------------------------------------
        // serial engine, low byte first on the wire
        // ------------------------------------------------------------
        case (q.st)
            ST_ADDR, ST_CMD, ST_WR: begin
                if (scl_rise) begin
                    n.sr = {q.sr[6:0], n.sda_f};
                    n.cnt = q.cnt + 4'h1;
                end
                if (scl_fall && q.cnt == 4'h8) begin
                    n.oe = 1'b1;
                    if (q.st == ST_ADDR) begin
                        n.rw = q.sr[0];
                        n.st = (q.sr[7:1] == DEV_ADDR) ? ST_AACK : ST_IDLE;
                        n.oe = (q.sr[7:1] == DEV_ADDR);
                    end else if (q.st == ST_CMD) begin
                        n.cmd = q.sr;
                        n.hi = 1'b0;
                        n.st = ST_CACK;
                    end else begin
                        n.st = ST_WACK;
                        n.hi = ~q.hi;
                        if (q.hi) begin
                            wr_fire = 1'b1;
                        end else begin
                            n.wlo = q.sr;
                        end
                    end
                end
            end
            ST_AACK: begin
                if (scl_fall) begin
                    n.cnt = 4'h0;
                    n.oe = 1'b0;
                    n.st = ST_CMD;
                    if (q.rw) begin
                        // snapshot so a new sample cannot tear the word
                        n.word = rd_mux;
                        n.tx = rd_mux[7:0];
                        n.oe = ~rd_mux[7];
                        n.hi = 1'b0;
                        n.st = ST_RD;
                    end
                end
            end
            ST_CACK, ST_WACK: begin
                if (scl_fall) begin
                    n.cnt = 4'h0;
                    n.oe = 1'b0;
                    n.st = ST_WR;
                end
            end
            ST_RD: begin
                n.cnt = q.cnt + {3'h0, scl_rise};
                if (scl_fall) begin
                    if (q.cnt == 4'h8) begin
                        n.oe = 1'b0;
                        n.st = ST_RACK;
                    end else begin
                        n.tx = {q.tx[6:0], 1'b0};
                        n.oe = ~q.tx[6];
                    end
                end
            end
            ST_RACK: begin
                n.nack = scl_rise ? n.sda_f : q.nack;
                if (scl_fall) begin
                    n.cnt = 4'h0;
                    n.st = ST_IDLE;
                    if (q.hi) begin
                        rd_done = 1'b1;
                    end else if (!q.nack) begin
                        n.hi = 1'b1;
                        n.tx = q.word[15:8];
                        n.oe = ~q.word[15];
                        n.st = ST_RD;
                    end
                end
            end
            default: begin
                n.st = ST_IDLE;
                n.oe = 1'b0;
            end
        endcase
        if (start_c) begin
            n.st = ST_ADDR;
            n.cnt = 4'h0;
            n.oe = 1'b0;
        end
        if (stop_c) begin
            n.st = ST_IDLE;
            n.oe = 1'b0;
        end
        // ------------------------------------------------------------
        // register writes; status and results have no write path
        // ------------------------------------------------------------
        if (wr_fire) begin
            case (q.cmd)
                `LSD_CMD_CFG: n.cfg = wr_word;
                `LSD_CMD_HTH: n.hthr = wr_word;
                `LSD_CMD_LTH: n.lthr = wr_word;
                `LSD_CMD_PWR: n.pwr = wr_word[2:0];
                default: n.pwr = q.pwr;
            endcase
        end
        // ------------------------------------------------------------
        // results and window flags; clear first so a new crossing wins
        // ------------------------------------------------------------
        if (rd_done && q.cmd == `LSD_CMD_STS) begin
            n.below = 1'b0;
            n.above = 1'b0;
        end
        if (SAMPLE_VALID) begin
            n.amb = AMBIENT_DATA;
            n.wht = WHITE_DATA;
            if (q.cfg[`LSD_CFG_IRQ_EN]) begin
                if (AMBIENT_DATA < q.lthr) begin
                    n.below = 1'b1;
                end
                if (AMBIENT_DATA > q.hthr) begin
                    n.above = 1'b1;
                end
            end
        end
        // ------------------------------------------------------------
        // refresh timer, held at zero while shut down
        // ------------------------------------------------------------
        if (q.cfg[`LSD_CFG_SHUTDOWN]) begin
            n.ms_cnt = 16'h0000;
            n.ref_ms = 13'h0000;
        end else if (q.ms_cnt >= MS_CYCLES - 16'h0001) begin
            n.ms_cnt = 16'h0000;
            if (q.ref_ms >= period - 13'h0001) begin
                n.ref_ms = 13'h0000;
                n.tick = 1'b1;
            end else begin
                n.ref_ms = q.ref_ms + 13'h0001;
            end
        end else begin
            n.ms_cnt = q.ms_cnt + 16'h0001;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.scl1 <= 1'b1;
            q.scl2 <= 1'b1;
            q.scl3 <= 1'b1;
            q.sda1 <= 1'b1;
            q.sda2 <= 1'b1;
            q.sda3 <= 1'b1;
            q.scl_f <= 1'b1;
            q.sda_f <= 1'b1;
            q.cfg <= `LSD_CFG_RST;
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign SDA_OUT = 1'b0;
    assign SDA_OE = q.oe;
    assign REFRESH_TICK = q.tick;
    assign SHUTDOWN = q.cfg[`LSD_CFG_SHUTDOWN];
    assign GAIN_SELECT = q.cfg[`LSD_CFG_GAIN_HI:`LSD_CFG_GAIN_LO];
    assign INTEGRATION_PERIOD = q.cfg[`LSD_CFG_IT_HI:`LSD_CFG_IT_LO];
    assign POWER_SAVE_ENABLE = q.pwr[`LSD_PWR_EN_BIT];
    assign POWER_SAVE_MODE = q.pwr[2:1];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);
    a_pwr_mode: assert property (wr_fire && q.cmd == `LSD_CMD_PWR |=>
        POWER_SAVE_MODE == $past(wr_word[2:1])) else $error("mode select not taken");
    a_pwr_enable: assert property (wr_fire && q.cmd == `LSD_CMD_PWR |=>
        POWER_SAVE_ENABLE == $past(wr_word[0])) else $error("enable not taken");
    a_pwr_reserved: assert property (q.st == ST_RD && q.cmd == `LSD_CMD_PWR |->
        q.word[15:3] == 13'h0000) else $error("reserved power bits not zero");
    a_amb_load: assert property (q.st == ST_AACK && scl_fall && q.rw &&
        q.cmd == `LSD_CMD_AMB && !start_c && !stop_c |=> q.word == $past(q.amb))
        else $error("ambient word wrong");
    a_byte_order: assert property (q.st == ST_RD && q.cnt == 4'h0 |->
        q.tx == (q.hi ? q.word[15:8] : q.word[7:0])) else $error("byte order wrong");
    a_wht_load: assert property (q.st == ST_AACK && scl_fall && q.rw &&
        q.cmd == `LSD_CMD_WHT && !start_c && !stop_c |=> q.word == $past(q.wht))
        else $error("white word wrong");
    a_below_set: assert property (SAMPLE_VALID && q.cfg[1] && AMBIENT_DATA < q.lthr
        |=> q.below) else $error("low crossing missed");
    a_above_set: assert property (SAMPLE_VALID && q.cfg[1] && AMBIENT_DATA > q.hthr
        |=> q.above) else $error("high crossing missed");
    a_hthr_write: assert property (wr_fire && q.cmd == `LSD_CMD_HTH |=>
        q.hthr == $past(wr_word)) else $error("high threshold not stored");
    a_lthr_write: assert property (wr_fire && q.cmd == `LSD_CMD_LTH |=>
        q.lthr == $past(wr_word)) else $error("low threshold not stored");
    a_irq_gate: assert property (!q.cfg[1] && !q.above && !q.below |=>
        !q.above && !q.below) else $error("flag set while disabled");
    a_tick_gap: assert property (REFRESH_TICK |=> !REFRESH_TICK ##1 !REFRESH_TICK)
        else $error("refresh ticks too close");
    a_flag_clear: assert property (rd_done && q.cmd == `LSD_CMD_STS && !SAMPLE_VALID
        |=> !q.above && !q.below) else $error("flags not cleared");
    a_sts_reserved: assert property (q.st == ST_RD && q.cmd == `LSD_CMD_STS |->
        q.word[13:0] == 14'h0000) else $error("reserved status bits not zero");

endmodule : lsd_core

// ==== verification/lsd_host_model.sv ====
// host side of the two-wire bus: start, stop, byte transfers and register access
// assumes: line is the wired data level with a pull-up; the caller starts on a rising CLK edge
`timescale 1ns/100ps

module lsd_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    // bus pins
    output logic scl,
    output logic sda,
    input wire logic line
);
    // idle bus: clock stands high outside frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // ------------------------------------------------------------
    // bit level, 160 ns per bit
    // ------------------------------------------------------------
    // data moves late in the low phase, 13 ns before the device's own release lands
    task automatic bitx(input logic b, output logic r);
        #60 sda = b;
        #20 scl = 1'b1;
        #40 r = line;
        #40 scl = 1'b0;
    endtask : bitx

    task automatic start_cond();
        #60 sda = 1'b1;
        #20 scl = 1'b1;
        #40 sda = 1'b0;
        #40 scl = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        #60 sda = 1'b0;
        #20 scl = 1'b1;
        #40 sda = 1'b1;
        #40;
    endtask : stop_cond

    task automatic xfer(input logic [7:0] b, input logic a, output logic [7:0] r,
                        output logic ar);
        for (int i = 7; i >= 0; i--) begin
            bitx(b[i], r[i]);
        end
        bitx(a, ar);
    endtask : xfer

    // ------------------------------------------------------------
    // register access, low byte first
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] c, input logic [15:0] v, output logic ok);
        logic [7:0] r;
        logic [3:0] n;
        #7;
        start_cond();
        xfer({DEV_ADDR, 1'b0}, 1'b1, r, n[0]);
        xfer(c, 1'b1, r, n[1]);
        xfer(v[7:0], 1'b1, r, n[2]);
        xfer(v[15:8], 1'b1, r, n[3]);
        stop_cond();
        ok = (n === 4'h0);
    endtask : wr

    task automatic rd(input logic [7:0] c, output logic [15:0] v, output logic ok);
        logic [7:0] r;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [2:0] n;
        logic x;
        #7;
        start_cond();
        xfer({DEV_ADDR, 1'b0}, 1'b1, r, n[0]);
        xfer(c, 1'b1, r, n[1]);
        start_cond();
        xfer({DEV_ADDR, 1'b1}, 1'b1, r, n[2]);
        xfer(8'hff, 1'b0, lo, x);
        xfer(8'hff, 1'b1, hi, x);
        stop_cond();
        v = {hi, lo};
        ok = (n === 3'h0);
    endtask : rd
endmodule : lsd_host_model

// ==== verification/tb_light_sensor_psm_data_status_regs.sv ====
// self-checking bench of the light sensor register core
// assumes: host model drives the bus pins, the bench plays the converter
`include "lsd_regs.svh"
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module tb_light_sensor_psm_data_status_regs;
    localparam int MSC = 2;  // 2 cycles a ms keeps refresh runs short
    localparam int LIMIT = 60000;  // run needs about 40000 cycles
    // refresh cases, first in the low bits: integration code, then power save word
    localparam logic [27:0] RCASES = {4'h8, 3'h0, 4'hc, 3'h7, 4'h1, 3'h3, 4'h0, 3'h0};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic sv = 1'b0;
    logic [15:0] amb = 16'h0000;
    logic [15:0] wht = 16'h0000;
    logic sda_o, sda_oe, tick, shut, ps_en, ok;
    logic [1:0] gain, ps_mode;
    logic [3:0] it;
    logic [15:0] d, a, w;
    logic [3:0] t;
    logic [2:0] p;
    wire scl, host_sda, sda_line;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int seed = 22475;
    int n;

    // open drain: either side pulls low, the pull-up wins otherwise
    assign sda_line = host_sda & (sda_oe ? sda_o : 1'b1);

    lsd_core #(.MS_CYCLES(16'(MSC))) dut_u (
        .CLK(clk), .RESETN(resetn), .SCL_IN(scl), .SDA_IN(sda_line), .SDA_OUT(sda_o),
        .SDA_OE(sda_oe), .SAMPLE_VALID(sv), .AMBIENT_DATA(amb), .WHITE_DATA(wht),
        .REFRESH_TICK(tick), .SHUTDOWN(shut), .GAIN_SELECT(gain),
        .INTEGRATION_PERIOD(it), .POWER_SAVE_ENABLE(ps_en), .POWER_SAVE_MODE(ps_mode));

    lsd_host_model host_u (.scl(scl), .sda(host_sda), .line(sda_line));

    initial begin
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    function automatic int period_ms(input logic [3:0] t, input logic e, input logic [1:0] m);
        int b;
        case (t)
            4'hc: b = 25;
            4'h8: b = 50;
            4'h1: b = 200;
            4'h2: b = 400;
            4'h3: b = 800;
            default: b = 100;
        endcase
        return e ? b + (500 << m) : b;
    endfunction : period_ms

    task automatic wr(input logic [7:0] c, input logic [15:0] v);
        @(posedge clk);
        host_u.wr(c, v, ok);
        `CHK("write ack", 1'b1, ok)
    endtask : wr

    task automatic rd(input logic [7:0] c, output logic [15:0] v);
        @(posedge clk);
        host_u.rd(c, v, ok);
        `CHK("read ack", 1'b1, ok)
    endtask : rd

    task automatic put_sample(input logic [15:0] av, input logic [15:0] wv);
        @(posedge clk);
        amb <= av;
        wht <= wv;
        sv <= 1'b1;
        @(posedge clk);
        sv <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : put_sample

    // cycles up to the next refresh pulse, bounded
    task automatic wait_tick(output int c);
        c = 0;
        do begin
            @(posedge clk);
            #1;
            c++;
        end while (!tick && c < 20000);
    endtask : wait_tick

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_errors++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        `CHK("shutdown at reset", 1'b1, shut)
        `CHK("enable at reset", 1'b0, ps_en)
        `CHK("mode at reset", 2'b00, ps_mode)
        `CHK("pin idle", 1'b0, sda_oe)
        // every mode with enable off and on, upper bits noise
        for (int i = 0; i < 8; i++) begin
            d = {13'($random(seed)), 3'(i)};
            wr(`LSD_CMD_PWR, d);
            `CHK("mode", 2'(i >> 1), ps_mode)
            `CHK("enable", 1'(i), ps_en)
            rd(`LSD_CMD_PWR, d);
            `CHK("mode readback", {13'h0000, 3'(i)}, d)
        end
        $display("power save test done");
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 16'hff00 : 16'($random(seed));
            w = (i == 0) ? 16'h00ff : 16'($random(seed));
            put_sample(a, w);
            rd(`LSD_CMD_AMB, d);
            `CHK("ambient", a, d)
            `CHK("ambient high byte", a[15:8], d[15:8])
            rd(`LSD_CMD_WHT, d);
            `CHK("white", w, d)
        end
        rd(8'h07, d);
        `CHK("unmapped", 16'h0000, d)
        $display("result test done");
        wr(`LSD_CMD_HTH, 16'h8000);
        wr(`LSD_CMD_LTH, 16'h1000);
        wr(`LSD_CMD_CFG, 16'h1802);
        `CHK("gain", 2'b11, gain)
        `CHK("powered on", 1'b0, shut)
        put_sample(16'h0fff, 16'h0000);
        rd(`LSD_CMD_STS, d);
        `CHK("below flag", 16'h8000, d)
        rd(`LSD_CMD_STS, d);
        `CHK("flags cleared", 16'h0000, d)
        put_sample(16'h8000, 16'h0000);
        rd(`LSD_CMD_STS, d);
        `CHK("at high bound", 16'h0000, d)
        put_sample(16'h8001, 16'h0000);
        rd(`LSD_CMD_STS, d);
        `CHK("above flag", 16'h4000, d)
        put_sample(16'h0000, 16'h0000);
        wr(`LSD_CMD_STS, 16'hffff);
        rd(`LSD_CMD_STS, d);
        `CHK("status read only", 16'h8000, d)
        wr(`LSD_CMD_CFG, 16'h0000);
        put_sample(16'h0000, 16'h0000);
        rd(`LSD_CMD_STS, d);
        `CHK("events disabled", 16'h0000, d)
        $display("window test done");
        // power save off and on, mode 4 and the shortest integration code included
        for (int i = 0; i < 4; i++) begin
            {t, p} = 7'(RCASES >> (7 * i));
            wr(`LSD_CMD_CFG, {6'h00, t, 6'h00});
            wr(`LSD_CMD_PWR, {13'h0000, p});
            `CHK("integration", t, it)
            `CHK("mode", p[2:1], ps_mode)
            wait_tick(n);
            wait_tick(n);
            `CHK("refresh period", period_ms(t, p[0], p[2:1]) * MSC, n)
        end
        $display("refresh test done");
        wrap_up();
    end
endmodule : tb_light_sensor_psm_data_status_regs
